//--- hdl/sbtc_pkg.sv
`default_nettype none
package sbtc_pkg;
   // ==========================================================
   // register byte offsets
   localparam logic [11:0] BASES_OFS = 12'h0C8;
   localparam logic [11:0] TIMING_OFS = 12'h0D0;
   localparam logic [11:0] STATUS_OFS = 12'h0D4;

   // ==========================================================
   // timing register fields (bit 0 of the printed map is bit 31 here)
   localparam int CAS_SEL_BIT = 28;
   localparam int ROW_CYC_LSB = 24;
   localparam int ACT_PRE_LSB = 20;
   localparam int SWR_BIT = 17;
   localparam int TDP_BIT = 16;
   localparam int TRP_BIT = 12;
   localparam int TRCD_BIT = 8;
   localparam logic [31:0] TIMING_RST = 32'h1333_1100;
   localparam logic [31:0] TIMING_WMASK = 32'h1733_1100;
   localparam logic [31:0] BASES_RST = 32'h0000_0000;

   // ==========================================================
   // base register byte lanes, block e in the top byte
   localparam int BLK_E_LSB = 24;
   localparam int BLK_F_LSB = 16;
   localparam int BLK_G_LSB = 8;
   localparam int BLK_H_LSB = 0;
   localparam int NUM_BLK = 4;

   // ==========================================================
   // status register fields
   localparam int MRS_PEND_BIT = 0;
   localparam int MRS_CL_LSB = 4;

   // ==========================================================
   // timers and clock counts
   localparam int NUM_TMR = 6;
   localparam int TMR_ROW_CYC = 0;
   localparam int TMR_ACT_PRE = 1;
   localparam int TMR_TRCD = 2;
   localparam int TMR_TRP = 3;
   localparam int TMR_TDP = 4;
   localparam int TMR_SWR = 5;
   localparam logic [3:0] SWR_CLKS = 4'h4;
   localparam logic [3:0] ROW_CYC_FALLBACK = 4'hB;
   localparam logic [1:0] CAS_LAT_2 = 2'h2;
   localparam logic [1:0] CAS_LAT_3 = 2'h3;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic activate;
      logic read_cmd;
      logic write_cmd;
      logic write_single;
      logic write_last;
      logic precharge;
   } sbtc_cmd_s;

   typedef struct packed {
      logic act_ok;
      logic rw_ok;
      logic pre_ok;
   } sbtc_permit_s;
endpackage : sbtc_pkg
`default_nettype wire

//--- hdl/sbtc_gap_timer.sv
`default_nettype none
module sbtc_gap_timer (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // event and minimum gap in clocks
   input wire logic start,
   input wire logic [3:0] gap_clks,
   // gap has elapsed
   output logic expired
);
   logic [3:0] cnt_r;
   logic [3:0] cnt_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      if (start) begin
         cnt_nxt = gap_clks - 4'h1;
      end else if (cnt_r != 4'h0) begin
         cnt_nxt = cnt_r - 4'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 4'h0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign expired = (cnt_r == 4'h0);
endmodule : sbtc_gap_timer
`default_nettype wire

//--- hdl/sbtc_config.sv
`default_nettype none
module sbtc_config (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // cpu address decode
   input wire logic [31:0] cpu_addr,
   input wire logic [3:0] blk_enable,
   input wire logic [11:0] blk_ign_bits,
   output logic [3:0] blk_hit,
   // sdram command events from the sequencer
   input wire sbtc_pkg::sbtc_cmd_s cmd,
   input wire logic refresh_done,
   output sbtc_pkg::sbtc_permit_s permit,
   // read data timing
   output logic rd_data_strobe,
   // mode register set handshake
   output logic mrs_req,
   output logic [1:0] mrs_cas_latency,
   input wire logic mrs_ack,
   // open page tracker
   output logic page_tracker_clear
);
   // ==========================================================
   // register state
   logic [31:0] bases_r;
   logic [31:0] bases_nxt;
   logic [31:0] timing_r;
   logic [31:0] timing_nxt;
   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;
   logic mrs_pend_r;
   logic mrs_pend_nxt;
   logic [1:0] mrs_cl_r;
   logic [1:0] mrs_cl_nxt;
   logic pg_clr_r;
   logic pg_clr_nxt;
   logic [2:0] rd_sh_r;
   logic [2:0] rd_sh_nxt;

   // ==========================================================
   // apb decode
   logic setup_ph;
   logic wr_acc;
   logic hit_bases;
   logic hit_timing;
   logic hit_status;
   logic mapped;
   logic cl_toggle;

   assign setup_ph = psel && !penable;
   assign wr_acc = psel && penable && pwrite;
   assign hit_bases = (paddr == sbtc_pkg::BASES_OFS);
   assign hit_timing = (paddr == sbtc_pkg::TIMING_OFS);
   assign hit_status = (paddr == sbtc_pkg::STATUS_OFS);
   assign mapped = hit_bases || hit_timing || hit_status;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = prdata_r;

   // write toggling the latency bit
   assign cl_toggle = wr_acc && hit_timing &&
      (pwdata[sbtc_pkg::CAS_SEL_BIT] !=
       timing_r[sbtc_pkg::CAS_SEL_BIT]);

   always_comb begin
      bases_nxt = bases_r;
      timing_nxt = timing_r;
      prdata_nxt = prdata_r;
      if (wr_acc && hit_bases) begin
         bases_nxt = pwdata;
      end
      if (wr_acc && hit_timing) begin
         timing_nxt = pwdata & sbtc_pkg::TIMING_WMASK;
      end
      if (setup_ph) begin
         prdata_nxt = 32'h0000_0000;
         if (hit_bases) begin
            prdata_nxt = bases_r;
         end else if (hit_timing) begin
            prdata_nxt = timing_r;
         end else if (hit_status) begin
            prdata_nxt[sbtc_pkg::MRS_PEND_BIT] = mrs_pend_r;
            prdata_nxt[sbtc_pkg::MRS_CL_LSB +: 2] = mrs_cl_r;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bases_r <= sbtc_pkg::BASES_RST;
         timing_r <= sbtc_pkg::TIMING_RST;
         prdata_r <= 32'h0000_0000;
      end else begin
         bases_r <= bases_nxt;
         timing_r <= timing_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   // ==========================================================
   // mode register set request
   always_comb begin
      mrs_pend_nxt = mrs_pend_r;
      mrs_cl_nxt = mrs_cl_r;
      if (mrs_ack) begin
         mrs_pend_nxt = 1'b0;
      end
      if (cl_toggle) begin
         mrs_pend_nxt = 1'b1;
         mrs_cl_nxt = pwdata[sbtc_pkg::CAS_SEL_BIT] ? sbtc_pkg::CAS_LAT_3 :
            sbtc_pkg::CAS_LAT_2;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mrs_pend_r <= 1'b0;
         mrs_cl_r <= sbtc_pkg::CAS_LAT_3;
      end else begin
         mrs_pend_r <= mrs_pend_nxt;
         mrs_cl_r <= mrs_cl_nxt;
      end
   end

   assign mrs_req = mrs_pend_r;
   assign mrs_cas_latency = mrs_cl_r;

   // ==========================================================
   // page tracker clear on refresh
   always_comb begin
      pg_clr_nxt = refresh_done;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pg_clr_r <= 1'b0;
      end else begin
         pg_clr_r <= pg_clr_nxt;
      end
   end

   assign page_tracker_clear = pg_clr_r;

   // ==========================================================
   // block address decode
   logic [7:0] blk_base [sbtc_pkg::NUM_BLK];
   assign blk_base[0] = bases_r[sbtc_pkg::BLK_E_LSB +: 8];
   assign blk_base[1] = bases_r[sbtc_pkg::BLK_F_LSB +: 8];
   assign blk_base[2] = bases_r[sbtc_pkg::BLK_G_LSB +: 8];
   assign blk_base[3] = bases_r[sbtc_pkg::BLK_H_LSB +: 8];

   genvar b;
   generate
      for (b = 0; b < sbtc_pkg::NUM_BLK; b++) begin : g_blk
         logic [7:0] cmp_mask;
         assign cmp_mask = 8'hFF << blk_ign_bits[3*b +: 3];
         assign blk_hit[b] = blk_enable[b] &&
            ((cpu_addr[31:24] & cmp_mask) ==
             (blk_base[b] & cmp_mask));
      end
   endgenerate

   // ==========================================================
   // minimum gap selection
   logic [2:0] row_cycle_min_code;
   logic [1:0] active_to_precharge_code;
   logic [3:0] row_cyc_gap;
   logic [3:0] gap_clks [sbtc_pkg::NUM_TMR];
   logic [sbtc_pkg::NUM_TMR-1:0] tmr_start;
   logic [sbtc_pkg::NUM_TMR-1:0] tmr_done;

   assign row_cycle_min_code = timing_r[sbtc_pkg::ROW_CYC_LSB +: 3];
   assign active_to_precharge_code = timing_r[sbtc_pkg::ACT_PRE_LSB +: 2];

   // one procedural driver for the row cycle gap, the array stays continuous
   always_comb begin
      unique case (row_cycle_min_code)
         3'h0: row_cyc_gap = 4'h8;
         3'h1: row_cyc_gap = 4'h9;
         3'h2: row_cyc_gap = 4'hA;
         3'h3: row_cyc_gap = 4'hB;
         3'h6: row_cyc_gap = 4'h6;
         3'h7: row_cyc_gap = 4'h7;
         default: row_cyc_gap = sbtc_pkg::ROW_CYC_FALLBACK;
      endcase
   end

   assign gap_clks[sbtc_pkg::TMR_ROW_CYC] = row_cyc_gap;
   assign gap_clks[sbtc_pkg::TMR_ACT_PRE] =
      4'h4 + {2'h0, active_to_precharge_code};
   assign gap_clks[sbtc_pkg::TMR_TRCD] =
      timing_r[sbtc_pkg::TRCD_BIT] ? 4'h3 : 4'h2;
   assign gap_clks[sbtc_pkg::TMR_TRP] =
      timing_r[sbtc_pkg::TRP_BIT] ? 4'h3 : 4'h2;
   assign gap_clks[sbtc_pkg::TMR_TDP] =
      timing_r[sbtc_pkg::TDP_BIT] ? 4'h2 : 4'h1;
   assign gap_clks[sbtc_pkg::TMR_SWR] = sbtc_pkg::SWR_CLKS;

   assign tmr_start[sbtc_pkg::TMR_ROW_CYC] = cmd.activate;
   assign tmr_start[sbtc_pkg::TMR_ACT_PRE] = cmd.activate;
   assign tmr_start[sbtc_pkg::TMR_TRCD] = cmd.activate;
   assign tmr_start[sbtc_pkg::TMR_TRP] = cmd.precharge;
   assign tmr_start[sbtc_pkg::TMR_TDP] = cmd.write_last;
   assign tmr_start[sbtc_pkg::TMR_SWR] = cmd.write_single &&
      timing_r[sbtc_pkg::SWR_BIT];

   genvar t;
   generate
      for (t = 0; t < sbtc_pkg::NUM_TMR; t++) begin : g_tmr
         sbtc_gap_timer u_tmr (
            .pclk(pclk),
            .presetn(presetn),
            .start(tmr_start[t]),
            .gap_clks(gap_clks[t]),
            .expired(tmr_done[t])
         );
      end
   endgenerate

   assign permit.act_ok = tmr_done[sbtc_pkg::TMR_ROW_CYC] &&
      tmr_done[sbtc_pkg::TMR_TRP];
   assign permit.rw_ok = tmr_done[sbtc_pkg::TMR_TRCD];
   assign permit.pre_ok = tmr_done[sbtc_pkg::TMR_ACT_PRE] &&
      tmr_done[sbtc_pkg::TMR_TDP] &&
      tmr_done[sbtc_pkg::TMR_SWR];

   // ==========================================================
   // read data strobe after cas latency
   always_comb begin
      rd_sh_nxt = {rd_sh_r[1:0], cmd.read_cmd};
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_sh_r <= 3'h0;
      end else begin
         rd_sh_r <= rd_sh_nxt;
      end
   end

   assign rd_data_strobe = timing_r[sbtc_pkg::CAS_SEL_BIT] ? rd_sh_r[2] :
      rd_sh_r[1];
endmodule : sbtc_config
`default_nettype wire

//--- tb/sbtc_config_asserts.sv
`default_nettype none
module sbtc_config_asserts (
   // clock, reset and apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // decode
   input wire logic [31:0] cpu_addr,
   input wire logic [3:0] blk_enable,
   input wire logic [11:0] blk_ign_bits,
   input wire logic [3:0] blk_hit,
   // sequencer side
   input wire sbtc_pkg::sbtc_cmd_s cmd,
   input wire logic refresh_done,
   input wire sbtc_pkg::sbtc_permit_s permit,
   input wire logic rd_data_strobe,
   input wire logic mrs_req,
   input wire logic [1:0] mrs_cas_latency,
   input wire logic mrs_ack,
   input wire logic page_tracker_clear
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ====
   // shadow of the timing register
   logic [31:0] tim_r, tim_nxt;
   logic wr_tim;
   always_comb begin
      wr_tim = psel & penable & pwrite & pready
         & (paddr == sbtc_pkg::TIMING_OFS);
      tim_nxt = wr_tim ? (pwdata & sbtc_pkg::TIMING_WMASK) : tim_r;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         tim_r <= sbtc_pkg::TIMING_RST;
      else
         tim_r <= tim_nxt;
   end
   // ====
   // properties
   sequence s_idle2; !rd_data_strobe [*2]; endsequence
   property p_cl2; cmd.read_cmd && !tim_r[28] |=> !rd_data_strobe
      ##1 rd_data_strobe; endproperty
   a_cl2: assert property (p_cl2) else $error("cl2 strobe off");
   property p_cas3; cmd.read_cmd && tim_r[28] |=> s_idle2
      ##1 rd_data_strobe; endproperty
   a_cas3: assert property (p_cas3) else $error("cas3 strobe off");
   property p_mrs; wr_tim && pwdata[28] != tim_r[28] |=> mrs_req
      && mrs_cas_latency == {1'h1, tim_r[28]}; endproperty
   a_mrs: assert property (p_mrs) else $error("no mode set");
   property p_hold; mrs_req && !mrs_ack |=> mrs_req; endproperty
   a_hold: assert property (p_hold) else $error("mode set lost");
   property p_clr; refresh_done |=> page_tracker_clear; endproperty
   a_clr: assert property (p_clr) else $error("no tracker clear");
   property p_trcd; cmd.activate |=> !permit.rw_ok
      ##1 (permit.rw_ok != tim_r[8]); endproperty
   a_trcd: assert property (p_trcd) else $error("rw gap off");
   property p_trp; cmd.precharge && permit.act_ok |=> !permit.act_ok
      ##1 (permit.act_ok != tim_r[12]); endproperty
   a_trp: assert property (p_trp) else $error("act gap off");
   property p_tdp; cmd.write_last && permit.pre_ok
      |=> (permit.pre_ok != tim_r[16]); endproperty
   a_tdp: assert property (p_tdp) else $error("pre gap off");
endmodule : sbtc_config_asserts
bind sbtc_config sbtc_config_asserts chk_u (.*);
`default_nettype wire

//--- tb/sbtc_mrs_model.sv
`default_nettype none
module sbtc_mrs_model #(
   parameter int DLY = 3
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // mode register set handshake
   input wire logic mrs_req,
   input wire logic [1:0] mrs_cas_latency,
   output logic mrs_ack,
   // latency held by the array
   output logic [1:0] array_cl
);
   timeunit 1ns;
   timeprecision 100ps;
   int cnt;
   // ====
   // array loads the latency after dly idle clocks
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 0;
         mrs_ack <= 1'h0;
         array_cl <= sbtc_pkg::CAS_LAT_3;
      end else begin
         mrs_ack <= mrs_req && !mrs_ack && cnt == DLY;
         cnt <= (mrs_req && !mrs_ack && cnt < DLY) ? cnt + 1 : 0;
         if (mrs_req && !mrs_ack && cnt == DLY)
            array_cl <= mrs_cas_latency;
      end
   end
endmodule : sbtc_mrs_model
`default_nettype wire

//--- tb/tb_top.sv
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
   fail_count++; $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); \
   end end
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
   logic pwrite = 1'h0, refresh_done = 1'h0;
   logic [11:0] paddr = '0, blk_ign_bits = 12'h8C0;
   logic [31:0] pwdata = '0, cpu_addr = '0, prdata, rd;
   logic [3:0] blk_enable = 4'hF, blk_hit, obs;
   logic pready, pslverr, rd_data_strobe, mrs_req, mrs_ack, err;
   logic page_tracker_clear;
   logic [1:0] mrs_cas_latency, array_cl;
   sbtc_pkg::sbtc_cmd_s cmd = '0;
   sbtc_pkg::sbtc_permit_s permit;
   int fail_count = 0, checks_done = 0;
   always #4 pclk = ~pclk;
   assign obs = {rd_data_strobe, permit};
   sbtc_config dut_u (.*);
   sbtc_mrs_model #(.DLY(3)) part_u (.*);
   // ====
   // bus cycle and shared checks
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1)
         @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   task automatic run(input logic [31:0] v, input logic [5:0] ev,
      input int s, input int n);
      int k;
      apb(1'h1, sbtc_pkg::TIMING_OFS, v);
      repeat (12) @(posedge pclk);
      cmd <= ev;
      @(posedge pclk);
      cmd <= '0;
      @(negedge pclk);
      k = 1;
      while (obs[s] !== 1'h1 && k < 20) begin
         @(negedge pclk);
         k++;
      end
      `CHK(k, n)
   endtask : run
   task automatic hit(input logic [31:0] a, input logic [3:0] h);
      cpu_addr <= a;
      @(negedge pclk);
      `CHK(blk_hit, h)
      @(posedge pclk);
   endtask : hit
   // ====
   // scenarios
   task automatic t_reset;
      `CHK(mrs_cas_latency, sbtc_pkg::CAS_LAT_3)
      apb(1'h0, sbtc_pkg::TIMING_OFS, '0);
      `CHK(rd, sbtc_pkg::TIMING_RST)
      apb(1'h1, 12'h0FC, 32'hFFFF_FFFF);
      `CHK(err, 1'h1)
      apb(1'h1, sbtc_pkg::TIMING_OFS, 32'hFFFF_FFFF);
      apb(1'h0, sbtc_pkg::TIMING_OFS, '0);
      `CHK(rd, sbtc_pkg::TIMING_WMASK)
      refresh_done <= 1'h1;
      @(posedge pclk);
      refresh_done <= 1'h0;
      @(negedge pclk);
      `CHK(page_tracker_clear, 1'h1)
      $display("reset test done");
   endtask : t_reset
   task automatic t_decode;
      apb(1'h1, sbtc_pkg::BASES_OFS, 32'h1256_3478);
      hit(32'h1200_0000, 4'h1);
      hit(32'h5600_0000, 4'h2);
      hit(32'h3700_0000, 4'h4);
      hit(32'h7A00_0000, 4'h8);
      blk_enable <= 4'h7;
      hit(32'h7A00_0000, 4'h0);
      $display("decode test done");
   endtask : t_decode
   task automatic t_mrs;
      apb(1'h1, sbtc_pkg::TIMING_OFS, 32'h0333_1100);
      @(negedge pclk);
      `CHK(mrs_req, 1'h1)
      `CHK(mrs_cas_latency, sbtc_pkg::CAS_LAT_2)
      repeat (12) @(negedge pclk);
      `CHK(array_cl, sbtc_pkg::CAS_LAT_2)
      apb(1'h1, sbtc_pkg::TIMING_OFS, 32'h0333_1100);
      @(negedge pclk);
      `CHK(mrs_req, 1'h0)
      $display("mode set test done");
   endtask : t_mrs
   task automatic t_gaps;
      int trc_n [8] = '{8, 9, 10, 11, 11, 11, 6, 7};
      for (int c = 0; c < 8; c++)
         run(32'h1033_1100 | (32'(c) << 24), 6'h20, 2, trc_n[c]);
      for (int c = 0; c < 4; c++)
         run(32'h1303_1100 | (32'(c) << 20), 6'h20, 0, 4 + c);
      run(32'h0333_1100, 6'h10, 3, 2);
      run(32'h1333_1100, 6'h10, 3, 3);
      run(32'h1333_1000, 6'h20, 1, 2);
      run(32'h1333_1100, 6'h20, 1, 3);
      run(32'h1333_0100, 6'h01, 2, 2);
      run(32'h1333_1100, 6'h01, 2, 3);
      run(32'h1332_1100, 6'h02, 0, 1);
      run(32'h1333_1100, 6'h02, 0, 2);
      run(32'h1331_1100, 6'h04, 0, 1);
      run(32'h1333_1100, 6'h04, 0, 4);
      $display("timing test done");
   endtask : t_gaps
   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : results
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'h1;
      t_reset;
      t_decode;
      t_mrs;
      t_gaps;
      results;
   end
   initial begin
      repeat (4000) @(posedge pclk);
      fail_count++;
      results;
   end
endmodule : tb_top
`default_nettype wire
